//--- admittance_pkg.sv
// Register map, fields, reset values, modes, types and timing counts
// of the neutral admittance protection block.
// Assumes a 32-bit Wishbone bus with byte addresses.
package admittance_pkg;

    // Phasor and arithmetic widths.
    localparam int PHASOR_W = 16;
    localparam int SET_W    = 16;
    localparam int FRAC_W   = 8;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] VOLT_THR_OFS  = 8'h04;
    localparam logic [7:0] Y_SET_OFS     = 8'h08;
    localparam logic [7:0] G_SET_OFS     = 8'h0C;
    localparam logic [7:0] B_SET_OFS     = 8'h10;
    localparam logic [7:0] CORR_OFS      = 8'h14;
    localparam logic [7:0] Y_DELAY_OFS   = 8'h18;
    localparam logic [7:0] G_DELAY_OFS   = 8'h1C;
    localparam logic [7:0] B_DELAY_OFS   = 8'h20;
    localparam logic [7:0] STATUS_OFS    = 8'h24;
    localparam logic [7:0] INT_STAT_OFS  = 8'h28;
    localparam logic [7:0] INT_MASK_OFS  = 8'h2C;
    localparam logic [7:0] MEAS_VSQ_OFS  = 8'h30;
    localparam logic [7:0] MEAS_ISQ_OFS  = 8'h34;
    localparam logic [7:0] MEAS_G_OFS    = 8'h38;
    localparam logic [7:0] MEAS_B_OFS    = 8'h3C;
    localparam logic [7:0] REC_VSQ_OFS   = 8'h40;
    localparam logic [7:0] REC_ISQ_OFS   = 8'h44;
    localparam logic [7:0] REC_G_OFS     = 8'h48;
    localparam logic [7:0] REC_B_OFS     = 8'h4C;
    localparam logic [7:0] REC_CTRL_OFS  = 8'h50;

    // Control register fields.
    localparam int CTRL_EN_LSB   = 0;
    localparam int CTRL_GDIR_LSB = 4;
    localparam int CTRL_BDIR_LSB = 6;
    localparam int CTRL_AR_LSB   = 8;
    localparam int CTRL_W        = 11;

    // Event bit positions in the status and interrupt registers.
    localparam int EV_START_LSB = 0;
    localparam int EV_TRIP_LSB  = 4;
    localparam int EV_W         = 7;
    localparam int STAT_VOK_BIT = 8;

    // Reset values.
    localparam logic [CTRL_W-1:0] CTRL_RST     = 11'h000;
    localparam logic [31:0]       VOLT_THR_RST = 32'h0000_0000;
    localparam logic [SET_W-1:0]  SET_RST      = 16'hFFFF;
    localparam logic [31:0]       CORR_RST     = 32'h0000_4000;
    localparam logic [SET_W-1:0]  DELAY_RST    = 16'h0000;

    // Timer tick of one millisecond at a 100 ns clock.
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        DIR_NONDIR  = 2'b00,
        DIR_FORWARD = 2'b01,
        DIR_REVERSE = 2'b10
    } dir_mode_e;

    typedef struct packed {
        logic signed [PHASOR_W-1:0] re;
        logic signed [PHASOR_W-1:0] im;
    } phasor_s;

    typedef struct packed {
        logic [31:0] v_sq;
        logic [31:0] i_sq;
        logic [31:0] cond;
        logic [31:0] susc;
    } meas_s;

endpackage : admittance_pkg

//--- neutral_admittance_protection.sv
// Neutral admittance protection: three single-stage elements with start,
// delayed trip and auto-reclose initiation, plus a Wishbone register file.
// Assumes phasors arrive on MCLK; block pins are asynchronous.
//
// What this block does
// - Admittance is neutral current over neutral voltage, from measured phasors.
// - Admittance element: non-directional, start, delayed trip, blockable trip.
// - Conductance element: optionally directional, start, delayed trip, blockable trip.
// - Susceptance element: optionally directional, start, delayed trip, blockable trip.
// - Trip only if neutral voltage stays above threshold for the whole delay.
// - Fast voltage transformer supervision block inhibits all three elements.
// - Admittance, conductance, susceptance readable and kept in the fault record.
// - Each element may initiate auto-reclose, gated by its own enable bit.
// - Admittance operates when magnitude exceeds pickup and voltage exceeds threshold.
// - Conductance: three modes; needs magnitude, direction and voltage.
// - Conductance directional boundary rotates by the correction angle.
// - Forward conductance centre lies where current is in phase with voltage.
// - Boundary measured from conductance axis; plus 30 degrees gives 60-240.
// - Susceptance: three modes; needs magnitude, direction and voltage.
// - Susceptance directional boundary rotates by the correction angle.
// - Forward susceptance centre lies where current leads voltage by 90 degrees.
// - Susceptance correction of plus 30 degrees gives boundary 330-150.
//
// The Wishbone register port and the register offsets were left to the implementer.

`timescale 1ns/1ps

module elem_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Timing
    input  wire logic        tick,
    input  wire logic [15:0] delay,
    // Element condition
    input  wire logic        arm,
    input  wire logic        block,
    output logic             trip
);
    logic [15:0] count;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
        end else if (!arm) begin
            count <= 16'h0000;
        end else if (tick && count != delay) begin
            count <= count + 16'h0001;
        end
    end

    // The arm input includes the voltage check, so a dip restarts the delay.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trip <= 1'b0;
        end else begin
            trip <= arm && count == delay && !block;
        end
    end
endmodule : elem_timer

module neutral_admittance_protection
    import admittance_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // Measured neutral phasors
    input  wire phasor_s     NEUTRAL_CURRENT,
    input  wire phasor_s     NEUTRAL_VOLTAGE,
    // Logic inputs, asynchronous
    input  wire logic [2:0]  TRIP_BLOCK,
    input  wire logic        VT_SUPERVISION_BLOCK,
    // Element outputs: bit 0 admittance, 1 conductance, 2 susceptance
    output logic      [2:0]  START,
    output logic      [2:0]  TRIP,
    output logic      [2:0]  AR_INIT,
    output logic             IRQ
);
    // Settings.
    logic [CTRL_W-1:0]      ctrl;
    logic [31:0]            volt_thr;
    logic [SET_W-1:0]       y_set;
    logic [SET_W-1:0]       g_set;
    logic [SET_W-1:0]       b_set;
    logic [31:0]            corr;
    logic [SET_W-1:0]       delay [3];
    logic [EV_W-1:0]        int_stat;
    logic [EV_W-1:0]        int_mask;
    // Synchronisers.
    logic [3:0]             blk_meta;
    logic [3:0]             blk_sync;
    // Arithmetic pipeline.
    logic signed [31:0]     ir_vr, ii_vi, ii_vr, ir_vi;
    logic signed [31:0]     ir_ir, ii_ii, vr_vr, vi_vi;
    logic signed [32:0]     p_re;
    logic signed [32:0]     p_im;
    logic [31:0]            i_sq;
    logic [31:0]            v_sq;
    logic signed [49:0]     rot_re;
    logic signed [49:0]     rot_im;
    logic                   volt_ok;
    logic                   y_mag, g_mag, b_mag;
    logic                   g_fwd, g_rev, b_fwd, b_rev;
    // Element state.
    logic [2:0]             start_c;
    logic [2:0]             trip_w;
    logic [2:0]             start_d;
    logic [2:0]             trip_d;
    logic [31:0]            tick_cnt;
    logic                   tick;
    meas_s                  meas;
    meas_s                  record;
    logic                   rec_valid;
    // Bus.
    logic                   bus_req;
    logic                   wr_en;
    logic [31:0]            rd_word;
    logic [31:0]            wr_word;
    logic signed [15:0]     corr_cos;
    logic signed [15:0]     corr_sin;
    dir_mode_e              g_mode;
    dir_mode_e              b_mode;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int k = 0; k < 4; k++) begin
            if (sel[k]) begin
                r[8*k +: 8] = new_v[8*k +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    function automatic logic [32:0] mag33(input logic signed [32:0] v);
        return v[32] ? 33'(-v) : v;
    endfunction : mag33

    assign corr_cos = corr[15:0];
    assign corr_sin = corr[31:16];
    assign g_mode   = dir_mode_e'(ctrl[CTRL_GDIR_LSB +: 2]);
    assign b_mode   = dir_mode_e'(ctrl[CTRL_BDIR_LSB +: 2]);

    // Block pins come from outside the clock domain.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            blk_meta <= 4'h0;
            blk_sync <= 4'h0;
        end else begin
            blk_meta <= {VT_SUPERVISION_BLOCK, TRIP_BLOCK};
            blk_sync <= blk_meta;
        end
    end

    // Stage one: partial products.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ir_vr <= '0;
            ii_vi <= '0;
            ii_vr <= '0;
            ir_vi <= '0;
            ir_ir <= '0;
            ii_ii <= '0;
            vr_vr <= '0;
            vi_vi <= '0;
        end else begin
            ir_vr <= NEUTRAL_CURRENT.re * NEUTRAL_VOLTAGE.re;
            ii_vi <= NEUTRAL_CURRENT.im * NEUTRAL_VOLTAGE.im;
            ii_vr <= NEUTRAL_CURRENT.im * NEUTRAL_VOLTAGE.re;
            ir_vi <= NEUTRAL_CURRENT.re * NEUTRAL_VOLTAGE.im;
            ir_ir <= NEUTRAL_CURRENT.re * NEUTRAL_CURRENT.re;
            ii_ii <= NEUTRAL_CURRENT.im * NEUTRAL_CURRENT.im;
            vr_vr <= NEUTRAL_VOLTAGE.re * NEUTRAL_VOLTAGE.re;
            vi_vi <= NEUTRAL_VOLTAGE.im * NEUTRAL_VOLTAGE.im;
        end
    end

    // Stage two: I times conj(V) is Y times |V| squared, so admittance is
    // compared without a divider by scaling each pickup by |V| squared.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            p_re <= '0;
            p_im <= '0;
            i_sq <= '0;
            v_sq <= '0;
        end else begin
            p_re <= 33'(ir_vr) + 33'(ii_vi);
            p_im <= 33'(ii_vr) - 33'(ir_vi);
            i_sq <= 32'(ir_ir) + 32'(ii_ii);
            v_sq <= 32'(vr_vr) + 32'(vi_vi);
        end
    end

    // Rotating the product turns the boundaries.
    assign rot_re = 50'(p_re) * 50'(corr_cos) - 50'(p_im) * 50'(corr_sin);
    assign rot_im = 50'(p_re) * 50'(corr_sin) + 50'(p_im) * 50'(corr_cos);

    // Stage three: magnitude, direction and voltage criteria.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            volt_ok <= 1'b0;
            y_mag   <= 1'b0;
            g_mag   <= 1'b0;
            b_mag   <= 1'b0;
            g_fwd   <= 1'b0;
            g_rev   <= 1'b0;
            b_fwd   <= 1'b0;
            b_rev   <= 1'b0;
        end else begin
            volt_ok <= v_sq > volt_thr;
            y_mag   <= {8'h00, i_sq, 8'h00} > 48'(y_set) * 48'(v_sq);
            g_mag   <= {7'h00, mag33(p_re), 8'h00} > 48'(g_set) * 48'(v_sq);
            b_mag   <= {7'h00, mag33(p_im), 8'h00} > 48'(b_set) * 48'(v_sq);
            // Forward centre is current in phase with voltage.
            g_fwd   <= !rot_re[49] && rot_re != '0;
            g_rev   <= rot_re[49];
            // Forward centre is current leading voltage by a quarter cycle.
            b_fwd   <= !rot_im[49] && rot_im != '0;
            b_rev   <= rot_im[49];
        end
    end

    // The supervision block removes every start.
    always_comb begin
        start_c[0] = ctrl[CTRL_EN_LSB] && y_mag && volt_ok;
        case (g_mode)
            DIR_NONDIR:  start_c[1] = g_mag;
            DIR_FORWARD: start_c[1] = g_mag && g_fwd;
            DIR_REVERSE: start_c[1] = g_mag && g_rev;
            default:     start_c[1] = 1'b0;
        endcase
        case (b_mode)
            DIR_NONDIR:  start_c[2] = b_mag;
            DIR_FORWARD: start_c[2] = b_mag && b_fwd;
            DIR_REVERSE: start_c[2] = b_mag && b_rev;
            default:     start_c[2] = 1'b0;
        endcase
        start_c[1] = start_c[1] && ctrl[CTRL_EN_LSB + 1] && volt_ok;
        start_c[2] = start_c[2] && ctrl[CTRL_EN_LSB + 2] && volt_ok;
        if (blk_sync[3]) begin
            start_c = 3'b000;
        end
    end

    // Millisecond tick for the delay timers.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (tick_cnt == 32'(TICK_LEN - 1)) begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    for (genvar e = 0; e < 3; e++) begin : g_elem
        elem_timer u_timer (
            .clk   (MCLK),
            .rst_n (RST_N),
            .tick  (tick),
            .delay (delay[e]),
            .arm   (start_c[e]),
            .block (blk_sync[e]),
            .trip  (trip_w[e])
        );
    end

    // Registered element outputs.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            START   <= 3'b000;
            AR_INIT <= 3'b000;
            start_d <= 3'b000;
            trip_d  <= 3'b000;
        end else begin
            START   <= start_c;
            AR_INIT <= trip_w & ctrl[CTRL_AR_LSB +: 3];
            start_d <= start_c;
            trip_d  <= trip_w;
        end
    end
    assign TRIP = trip_w;

    // The record freezes at the first trip; later fault values cannot overwrite it until a one is written to bit 0 at REC_CTRL_OFS.
    assign meas.v_sq = v_sq;
    assign meas.i_sq = i_sq;
    assign meas.cond = p_re[32:1];
    assign meas.susc = p_im[32:1];

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            record    <= '0;
            rec_valid <= 1'b0;
        end else if (!rec_valid && |(trip_w & ~trip_d)) begin
            record    <= meas;
            rec_valid <= 1'b1;
        end else if (wr_en && WB_ADR_I[7:2] == REC_CTRL_OFS[7:2]
                     && WB_SEL_I[0] && WB_DAT_I[0]) begin
            rec_valid <= 1'b0;
        end
    end

    // Wishbone slave: ack one cycle after the request, dropped the next.
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr_en   = bus_req && WB_WE_I;
    assign wr_word = merge_bytes(rd_word, WB_DAT_I, WB_SEL_I);

    always_comb begin
        case (WB_ADR_I[7:2])
            CTRL_OFS[7:2]:     rd_word = 32'(ctrl);
            VOLT_THR_OFS[7:2]: rd_word = volt_thr;
            Y_SET_OFS[7:2]:    rd_word = 32'(y_set);
            G_SET_OFS[7:2]:    rd_word = 32'(g_set);
            B_SET_OFS[7:2]:    rd_word = 32'(b_set);
            CORR_OFS[7:2]:     rd_word = corr;
            Y_DELAY_OFS[7:2]:  rd_word = 32'(delay[0]);
            G_DELAY_OFS[7:2]:  rd_word = 32'(delay[1]);
            B_DELAY_OFS[7:2]:  rd_word = 32'(delay[2]);
            STATUS_OFS[7:2]:   rd_word = {23'h00_0000, volt_ok, 1'b0, trip_w, 1'b0, START};
            INT_STAT_OFS[7:2]: rd_word = 32'(int_stat);
            INT_MASK_OFS[7:2]: rd_word = 32'(int_mask);
            MEAS_VSQ_OFS[7:2]: rd_word = meas.v_sq;
            MEAS_ISQ_OFS[7:2]: rd_word = meas.i_sq;
            MEAS_G_OFS[7:2]:   rd_word = meas.cond;
            MEAS_B_OFS[7:2]:   rd_word = meas.susc;
            REC_VSQ_OFS[7:2]:  rd_word = record.v_sq;
            REC_ISQ_OFS[7:2]:  rd_word = record.i_sq;
            REC_G_OFS[7:2]:    rd_word = record.cond;
            REC_B_OFS[7:2]:    rd_word = record.susc;
            REC_CTRL_OFS[7:2]: rd_word = {31'h0000_0000, rec_valid};
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req;
            WB_DAT_O <= bus_req && !WB_WE_I ? rd_word : 32'h0000_0000;
        end
    end

    // Settings registers.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl     <= CTRL_RST;
            volt_thr <= VOLT_THR_RST;
            y_set    <= SET_RST;
            g_set    <= SET_RST;
            b_set    <= SET_RST;
            corr     <= CORR_RST;
            delay[0] <= DELAY_RST;
            delay[1] <= DELAY_RST;
            delay[2] <= DELAY_RST;
            int_mask <= '0;
        end else if (wr_en) begin
            case (WB_ADR_I[7:2])
                CTRL_OFS[7:2]:     ctrl     <= wr_word[CTRL_W-1:0];
                VOLT_THR_OFS[7:2]: volt_thr <= wr_word;
                Y_SET_OFS[7:2]:    y_set    <= wr_word[SET_W-1:0];
                G_SET_OFS[7:2]:    g_set    <= wr_word[SET_W-1:0];
                B_SET_OFS[7:2]:    b_set    <= wr_word[SET_W-1:0];
                CORR_OFS[7:2]:     corr     <= wr_word;
                Y_DELAY_OFS[7:2]:  delay[0] <= wr_word[SET_W-1:0];
                G_DELAY_OFS[7:2]:  delay[1] <= wr_word[SET_W-1:0];
                B_DELAY_OFS[7:2]:  delay[2] <= wr_word[SET_W-1:0];
                INT_MASK_OFS[7:2]: int_mask <= wr_word[EV_W-1:0];
                default:           ctrl     <= ctrl;
            endcase
        end
    end

    // Sticky events, cleared by writing one; a new event beats the clear.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            int_stat <= '0;
            IRQ      <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~((wr_en && WB_ADR_I[7:2] == INT_STAT_OFS[7:2])
                                      ? WB_DAT_I[EV_W-1:0] & {EV_W{WB_SEL_I[0]}} : 7'h00))
                        | {trip_w & ~trip_d, 1'b0, start_c & ~start_d};
            IRQ      <= |(int_stat & int_mask);
        end
    end

endmodule : neutral_admittance_protection

//--- nap_assertions.sv
// Port checks for the neutral admittance protection block.
// Assumes one MCLK domain and a bind from the testbench.
`timescale 1ns/1ps
module nap_assertions
    import admittance_pkg::*;
#(
    parameter int TICK_LEN = 4
) (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // Register bus
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // Element pins
    input wire logic [2:0]  TRIP_BLOCK,
    input wire logic        VT_SUPERVISION_BLOCK,
    input wire logic [2:0]  START,
    input wire logic [2:0]  TRIP,
    input wire logic [2:0]  AR_INIT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    // Block pins pass synchronisers; a block counts after five edges.
    logic [11:0] blk_sr;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            blk_sr <= 12'h000;
        end else begin
            blk_sr <= {blk_sr[8:0], TRIP_BLOCK};
        end
    end

    sequence bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence vt_held;
        VT_SUPERVISION_BLOCK [*6];
    endsequence

    chk_ack_latency: assert property (bus_req |=> WB_ACK_O)
        else $error("no ack");
    chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    chk_read_quiet: assert property ((!WB_ACK_O || WB_WE_I) |-> WB_DAT_O == 32'h0000_0000)
        else $error("stray read data");
    chk_vt_inhibit: assert property (vt_held |-> START == 3'h0 && TRIP == 3'h0)
        else $error("active under block");
    chk_trip_block: assert property ((TRIP & TRIP_BLOCK & blk_sr[2:0] & blk_sr[5:3]
        & blk_sr[8:6] & blk_sr[11:9]) == 3'h0)
        else $error("trip while blocked");
    chk_ar_cause: assert property ((AR_INIT & ~$past(TRIP)) == 3'h0)
        else $error("reclose without trip");
    chk_trip_start: assert property ((TRIP & ~START & ~$past(START)) == 3'h0)
        else $error("trip without start");
    chk_drop_clears: assert property ($fell(START[0]) |-> ##[0:1] !TRIP[0])
        else $error("trip survives start drop");
endmodule : nap_assertions

//--- phasor_source.sv
// Front end model handing neutral phasors to the block.
// Assumes the bench commands values and lag.
`timescale 1ns/1ps
module phasor_source
    import admittance_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Commanded values
    input  wire phasor_s    i_cmd,
    input  wire phasor_s    v_cmd,
    input  wire logic [3:0] lag,
    // Towards the block
    output phasor_s         i_out,
    output phasor_s         v_out
);
    // New estimates appear only after the filter settles.
    phasor_s    i_hold;
    phasor_s    v_hold;
    logic [3:0] wait_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            i_hold   <= '0;
            v_hold   <= '0;
            wait_cnt <= 4'h0;
        end else if ({i_cmd, v_cmd} != {i_hold, v_hold}) begin
            i_hold   <= i_cmd;
            v_hold   <= v_cmd;
            wait_cnt <= lag;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            i_out <= '0;
            v_out <= '0;
        end else if (wait_cnt == 4'h0) begin
            i_out <= i_hold;
            v_out <= v_hold;
        end
    end
endmodule : phasor_source

//--- testbench.sv
// Self-checking bench for the admittance block.
// Assumes phasor_source as front end; binds nap_assertions.
`timescale 1ns/1ps
module testbench
    import admittance_pkg::*;
#(
    parameter int TL = 4
);
    logic        mclk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack;
    phasor_s     cur, volt;
    phasor_s     i_cmd = '0;
    phasor_s     v_cmd = 32'h0064_0000;
    logic [3:0]  lag = 4'h0;
    logic [2:0]  blk = 3'h0;
    logic        vt = 1'b0;
    logic [2:0]  st, tr, ar;
    logic        irq;
    logic        snap = 1'b0;
    logic [31:0] q_rd[$];
    logic [9:0]  q_out[$];
    int          errors = 0;
    int          compares = 0;
    int          seed = 2;
    int          cycles = 0;
    logic [7:0]  ra [6] = '{CTRL_OFS, CORR_OFS, Y_SET_OFS, B_DELAY_OFS, INT_MASK_OFS, 8'h7C};
    logic [31:0] rv [6] = '{32'h0, 32'h0000_4000, 32'h0000_FFFF, 32'h0, 32'h0, 32'h0};
    logic [2:0]  ce [4] = '{3'h4, 3'h0, 3'h2, 3'h6};

    always #50 mclk = ~mclk;

    neutral_admittance_protection #(.TICK_LEN(TL)) uut (
        .MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .NEUTRAL_CURRENT(cur), .NEUTRAL_VOLTAGE(volt), .TRIP_BLOCK(blk),
        .VT_SUPERVISION_BLOCK(vt), .START(st), .TRIP(tr), .AR_INIT(ar), .IRQ(irq));
    phasor_source fe (.clk(mclk), .rst_n(rst_n), .i_cmd(i_cmd), .v_cmd(v_cmd), .lag(lag),
        .i_out(cur), .v_out(volt));

    task automatic end_of_test;
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic cmp_rd(input logic [31:0] got);
        logic [31:0] e;
        e = q_rd.pop_front();
        compares++;
        if (got !== e) begin
            errors++;
            $display("ERROR %0t read %h exp %h", $time, got, e);
        end
    endtask : cmp_rd

    task automatic cmp_out(input logic [9:0] got);
        logic [9:0] e;
        e = q_out.pop_front();
        compares++;
        if (got !== e) begin
            errors++;
            $display("ERROR %0t out %h exp %h", $time, got, e);
        end
    endtask : cmp_out

    always @(posedge mclk) begin
        cycles++;
        if (ack === 1'b1 && we === 1'b0)
            cmp_rd(dat_o);
        if (snap === 1'b1)
            cmp_out({irq, ar, tr, st});
        if (cycles == 6000) begin
            errors++;
            $display("ERROR %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= d;
        @(posedge mclk);
        while (ack !== 1'b1) @(posedge mclk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Let the monitor compare the outputs after n edges.
    task automatic chk(input int n, input logic [9:0] e);
        repeat (n) @(posedge mclk);
        q_out.push_back(e);
        snap <= 1'b1;
        @(posedge mclk);
        snap <= 1'b0;
    endtask : chk

    task automatic set_i(input int re, input int im);
        i_cmd.re <= re[15:0];
        i_cmd.im <= im[15:0];
    endtask : set_i

    // Voltage is (100, 0) and all pickups are 16.
    function automatic logic [2:0] dir_exp(input int d, input int re, input int im);
        logic [2:0] s;
        s[0] = (re * re + im * im) * 256 > 16 * 10000;
        s[1] = re != 0 && (d == 0 || (d == 1) == (re > 0));
        s[2] = im != 0 && (d == 0 || (d == 1) == (im > 0));
        return s;
    endfunction : dir_exp

    initial begin
        int         d, a, re, im;
        logic [2:0] s;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        for (int k = 0; k < 6; k++)
            rd(ra[k], rv[k]);
        chk(1, 10'h000);
        wr(VOLT_THR_OFS, 32'h0000_270F);
        for (int k = 0; k < 3; k++)
            wr(Y_SET_OFS + 8'(4 * k), 32'h0000_0010);
        wr(REC_CTRL_OFS, 32'h0000_0001);
        set_i(50, 0);
        chk(14, 10'h000);
        wr(CTRL_OFS, 32'h0000_0107);
        chk(8, 10'h05B);
        rd(MEAS_VSQ_OFS, 32'h0000_2710);
        rd(MEAS_ISQ_OFS, 32'h0000_09C4);
        rd(MEAS_G_OFS, 32'h0000_09C4);
        rd(REC_VSQ_OFS, 32'h0000_2710);
        rd(REC_CTRL_OFS, 32'h0000_0001);
        wr(VOLT_THR_OFS, 32'h0000_2710);
        chk(6, 10'h000);
        wr(VOLT_THR_OFS, 32'h0000_270F);
        vt <= 1'b1;
        chk(8, 10'h000);
        vt <= 1'b0;
        chk(8, 10'h05B);
        for (int k = 0; k < 12; k++) begin
            d  = k / 4;
            a  = 10 + ($random(seed) & 63);
            re = (k % 4 == 0) ? a : (k % 4 == 1) ? -a : 0;
            im = (k % 4 == 2) ? a : (k % 4 == 3) ? -a : 0;
            lag <= 4'($random(seed) & 3);
            wr(CTRL_OFS, 32'({3'h7, d[1:0], d[1:0], 4'h7}));
            set_i(re, im);
            s = dir_exp(d, re, im);
            chk(14, {1'b0, s, s, s});
        end
        wr(CORR_OFS, 32'h2000_376D);
        for (int k = 0; k < 4; k++) begin
            d = 1 + k / 2;
            wr(CTRL_OFS, 32'({3'h0, d[1:0], d[1:0], 4'h6}));
            set_i(k % 2 ? -47 : 17, k % 2 ? 17 : 47);
            chk(14, {4'h0, ce[k], ce[k]});
        end
        wr(CORR_OFS, 32'h0000_4000);
        wr(VOLT_THR_OFS, 32'h0000_2710);
        wr(CTRL_OFS, 32'h0000_0001);
        set_i(50, 0);
        wr(Y_DELAY_OFS, 32'h0000_0005);
        chk(10, 10'h000);
        wr(VOLT_THR_OFS, 32'h0000_270F);
        chk(6, 10'h001);
        wr(VOLT_THR_OFS, 32'h0000_2710);
        wr(VOLT_THR_OFS, 32'h0000_270F);
        chk(12, 10'h001);
        chk(30, 10'h009);
        blk <= 3'h1;
        chk(6, 10'h001);
        blk <= 3'h0;
        chk(6, 10'h009);
        rd(STATUS_OFS, 32'h0000_0111);
        wr(INT_MASK_OFS, 32'h0000_0001);
        chk(2, 10'h209);
        rd(INT_STAT_OFS, 32'h0000_0077);
        wr(INT_STAT_OFS, 32'h0000_0077);
        chk(2, 10'h009);
        rd(INT_STAT_OFS, 32'h0000_0000);
        @(posedge mclk);
        end_of_test();
    end
endmodule : testbench

bind neutral_admittance_protection nap_assertions #(.TICK_LEN(TICK_LEN)) chk_i (
    .MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TRIP_BLOCK(TRIP_BLOCK),
    .VT_SUPERVISION_BLOCK(VT_SUPERVISION_BLOCK), .START(START), .TRIP(TRIP),
    .AR_INIT(AR_INIT));
